/* File: verilog/dcel_pkg.sv */
// Shared constants and carrier types for the DMA channel event latch.
// Assumes a single clock domain; all users refer to names as dcel_pkg::name.
package dcel_pkg;

  // ------------------------------------------------------------------
  // Channel geometry
  // ------------------------------------------------------------------
  localparam int unsigned NUM_CH   = 32;
  localparam int unsigned CH_IDX_W = 5;
  localparam int unsigned REGION_W = 3;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;

  // ------------------------------------------------------------------
  // Register byte offsets and reset values
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_EVENT_LATCH      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CLEAR      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MANUAL_SET = 8'h10;

  localparam logic [DATA_W-1:0] RST_EVENT_LATCH      = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_EVENT_MANUAL_SET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_MISSED           = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO            = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ALL_ONES             = 32'hFFFF_FFFF;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                valid;
    logic                write;
    logic                shadow;
    logic [REGION_W-1:0] region;
    logic [ADDR_W-1:0]   offset;
    logic [DATA_W-1:0]   wdata;
  } dcel_reg_req_t;

  typedef struct packed {
    logic              valid;
    logic              error;
    logic [DATA_W-1:0] rdata;
  } dcel_reg_rsp_t;

  typedef struct packed {
    logic                valid;
    logic [CH_IDX_W-1:0] channel;
  } dcel_submit_t;

endpackage : dcel_pkg

/* File: verilog/dcel_access_gate.sv */
// Address decode and shadow region gating for the channel registers.
// Assumes region enable vectors come from registers held elsewhere.
`timescale 1ns/1ps
`default_nettype none

module dcel_access_gate #(
  parameter int unsigned NUM_REGIONS = 8
) (
  input  wire  dcel_pkg::dcel_reg_req_t                        req,
  input  wire  logic [NUM_REGIONS-1:0][dcel_pkg::DATA_W-1:0]   region_access_enable,
  output logic [dcel_pkg::DATA_W-1:0]                          acc_mask,
  output logic                                                 sel_latch,
  output logic                                                 sel_clear,
  output logic                                                 sel_set,
  output logic                                                 mapped
);

  // ------------------------------------------------------------------
  // Region gating
  // ------------------------------------------------------------------
  // A region index past the implemented count sees no channel at all
  wire region_ok = (32'(req.region) < NUM_REGIONS);
  wire [dcel_pkg::DATA_W-1:0] shadow_mask =
    region_ok ? region_access_enable[req.region] : dcel_pkg::READ_ZERO;

  assign acc_mask  = req.shadow ? shadow_mask : dcel_pkg::ALL_ONES;

  // ------------------------------------------------------------------
  // Offset decode
  // ------------------------------------------------------------------
  assign sel_latch = (req.offset == dcel_pkg::OFS_EVENT_LATCH);
  assign sel_clear = (req.offset == dcel_pkg::OFS_EVENT_CLEAR);
  assign sel_set   = (req.offset == dcel_pkg::OFS_EVENT_MANUAL_SET);
  assign mapped    = sel_latch | sel_clear | sel_set;

endmodule : dcel_access_gate

`default_nettype wire

/* File: verilog/dcel_event_latch.sv */
// Per-channel event capture for a 32-channel DMA channel controller.
// Assumes synchronous event pulses, a prioritiser that submits one
// channel per cycle, and enable/region vectors held in outside registers.
//
// Operation
// - One bit per channel in each register, bit index equals channel number.
// - Registers reachable globally and via shadow regions gated per channel.
// - Every external event sets its latch bit, enabled or not.
// - Only enabled latched events are presented to the prioritiser.
// - Submission of a channel's request clears its latch bit.
// - Event on set, enabled latch bit raises the missed-event flag.
// - Writing 1 to clear register clears latch bit; reads as zero.
// - Event set beats concurrent clear; already-set enabled bit flags a miss.
// - Latch bit holds until submitted or cleared by software.
// - Latch register reads 1 for pending events, 0 otherwise.
// - Writing 1 to manual set makes channel a candidate; 0 does nothing.
// - Manual set is independent of latch and ignores the enable mask.
// - Clear register never touches manual bits; only submission clears them.
// - Manual set beats concurrent submission clear; already set flags a miss.
// - Writing 1 to an already set manual bit flags a miss.
// - Enable mask gates only external events, not chained or manual ones.
`timescale 1ns/1ps
`default_nettype none

module dcel_event_latch #(
  parameter int unsigned NUM_REGIONS = 8
) (
  input  wire  logic                                          clk,
  input  wire  logic                                          arst_n,
  input  wire  logic [dcel_pkg::NUM_CH-1:0]                   ext_event,
  input  wire  logic [dcel_pkg::NUM_CH-1:0]                   enable_mask,
  input  wire  logic [dcel_pkg::NUM_CH-1:0]                   chained_event_vector,
  input  wire  logic [NUM_REGIONS-1:0][dcel_pkg::DATA_W-1:0]  region_access_enable,
  input  wire  dcel_pkg::dcel_reg_req_t                       reg_req,
  output var dcel_pkg::dcel_reg_rsp_t                         reg_rsp,
  input  wire  dcel_pkg::dcel_submit_t                        submit,
  output logic [dcel_pkg::NUM_CH-1:0]                         pending_req,
  output logic [dcel_pkg::NUM_CH-1:0]                         missed_event_flag
);

  localparam int unsigned N = dcel_pkg::NUM_CH;

  // ------------------------------------------------------------------
  // Register access decode
  // ------------------------------------------------------------------
  logic [dcel_pkg::DATA_W-1:0] acc_mask;
  logic                        sel_latch;
  logic                        sel_clear;
  logic                        sel_set;
  logic                        mapped;

  dcel_access_gate #(
    .NUM_REGIONS (NUM_REGIONS)
  ) u_gate (
    .req                  (reg_req),
    .region_access_enable (region_access_enable),
    .acc_mask             (acc_mask),
    .sel_latch            (sel_latch),
    .sel_clear            (sel_clear),
    .sel_set              (sel_set),
    .mapped               (mapped)
  );

  wire wr_req = reg_req.valid & reg_req.write;
  wire rd_req = reg_req.valid & ~reg_req.write;

  // Shadow writes only reach the channels the region owns
  wire [N-1:0] sw_clear = (wr_req & sel_clear) ?
                          (reg_req.wdata & acc_mask) : '0;
  wire [N-1:0] sw_set   = (wr_req & sel_set) ?
                          (reg_req.wdata & acc_mask) : '0;

  // ------------------------------------------------------------------
  // Channel state
  // ------------------------------------------------------------------
  logic [N-1:0] latch_q;
  logic [N-1:0] latch_d;
  logic [N-1:0] manual_q;
  logic [N-1:0] manual_d;
  logic [N-1:0] missed_q;
  logic [N-1:0] missed_d;
  logic [N-1:0] hw_clear;
  logic [N-1:0] latch_keep;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      // Bit g belongs to channel g in every vector
      assign hw_clear[g] = submit.valid &
                           (32'(submit.channel) == g);
      assign latch_keep[g] = latch_q[g] & ~hw_clear[g] & ~sw_clear[g];
      // Event capture ignores the enable; set has priority over clears
      assign latch_d[g]  = ext_event[g] | latch_keep[g];
      // Clear register is not part of this term on purpose
      assign manual_d[g] = sw_set[g] | (manual_q[g] & ~hw_clear[g]);
      // A miss is only counted for events the channel would have served
      assign missed_d[g] =
        (ext_event[g] & latch_q[g] & enable_mask[g]) |
        (sw_set[g] & manual_q[g]);
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_q  <= dcel_pkg::RST_EVENT_LATCH;
      manual_q <= dcel_pkg::RST_EVENT_MANUAL_SET;
      missed_q <= dcel_pkg::RST_MISSED;
    end else begin
      latch_q  <= latch_d;
      manual_q <= manual_d;
      missed_q <= missed_d;
    end
  end

  // ------------------------------------------------------------------
  // Prioritiser view
  // ------------------------------------------------------------------
  // Disabled latched events stay visible to software but are never served
  assign pending_req = (latch_q & enable_mask) | manual_q |
                       chained_event_vector;
  assign missed_event_flag = missed_q;

  // ------------------------------------------------------------------
  // Read and response path
  // ------------------------------------------------------------------
  wire [dcel_pkg::DATA_W-1:0] rd_raw =
    sel_latch ? latch_q  :
    sel_set   ? manual_q :
    dcel_pkg::READ_ZERO;

  dcel_pkg::dcel_reg_rsp_t rsp_q;
  dcel_pkg::dcel_reg_rsp_t rsp_d;

  always_comb begin
    rsp_d.valid = reg_req.valid;
    rsp_d.error = reg_req.valid & ~mapped;
    rsp_d.rdata = rd_req ? (rd_raw & acc_mask) : dcel_pkg::READ_ZERO;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign reg_rsp = rsp_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [N-1:0] ev_en_set;
  assign ev_en_set = ext_event & latch_q & enable_mask;

  sequence s_manual_write;
    wr_req && sel_set && (sw_set != '0);
  endsequence

  sequence s_manual_seen;
    ((manual_q & $past(sw_set)) == $past(sw_set)) ##0
    ((pending_req & $past(sw_set)) == $past(sw_set));
  endsequence

  a_event_always_set: assert property (
    (ext_event != '0) |=> ((latch_q & $past(ext_event)) == $past(ext_event)))
    else $error("external event not latched");

  a_latch_holds: assert property (
    1'b1 |=> ((latch_q & $past(latch_keep)) == $past(latch_keep)))
    else $error("latch bit dropped without clear");

  a_disabled_hidden: assert property (
    ((manual_q | chained_event_vector) == '0) |->
    (pending_req == (latch_q & enable_mask)))
    else $error("disabled event presented");

  a_submit_clears: assert property (
    (submit.valid && !ext_event[submit.channel] &&
     !sw_set[submit.channel]) |=>
    (!latch_q[$past(submit.channel)] && !manual_q[$past(submit.channel)]))
    else $error("submission did not clear channel");

  a_missed_raise: assert property (
    (ev_en_set != '0) |=> ((missed_event_flag & $past(ev_en_set)) ==
                            $past(ev_en_set)))
    else $error("missed event not flagged");

  a_sw_clear_only: assert property (
    (wr_req && sel_clear && !reg_req.shadow && ext_event == '0) |=>
    ((latch_q & $past(reg_req.wdata)) == '0) ##0
    ((manual_q & $past(manual_q) & ~$past(hw_clear)) ==
     ($past(manual_q) & ~$past(hw_clear))))
    else $error("clear write misbehaved");

  a_manual_pending: assert property (
    s_manual_write |=> s_manual_seen)
    else $error("manual set not pending");

  a_manual_repeat: assert property (
    (s_manual_write and ((sw_set & manual_q) != '0)) |=>
    ((missed_event_flag & $past(manual_q)) != '0))
    else $error("repeat manual set not flagged");

  a_clear_reads_zero: assert property (
    (rd_req && sel_clear) |=> (reg_rsp.valid && reg_rsp.rdata == '0))
    else $error("clear register read non-zero");

  // ------------------------------------------------------------------
  // Collision and bookkeeping checks
  // ------------------------------------------------------------------
  // Helper vectors keep the properties short; they only feed assertions
  logic [N-1:0] ev_vs_clr;
  logic [N-1:0] ev_vs_clr_miss;
  logic [N-1:0] man_vs_sub;
  logic [N-1:0] man_keep;
  assign ev_vs_clr      = ext_event & (sw_clear | hw_clear);
  assign ev_vs_clr_miss = ev_vs_clr & latch_q & enable_mask;
  assign man_vs_sub     = sw_set & hw_clear;
  assign man_keep       = manual_q & ~hw_clear;

  sequence s_collide;
    ev_vs_clr != '0;
  endsequence

  sequence s_collide_kept;
    (latch_q & $past(ev_vs_clr)) == $past(ev_vs_clr);
  endsequence

  sequence s_manual_race;
    man_vs_sub != '0;
  endsequence

  sequence s_manual_race_kept;
    (manual_q & $past(man_vs_sub)) == $past(man_vs_sub);
  endsequence

  a_set_beats_clear: assert property (
    s_collide |=> s_collide_kept)
    else $error("clear won over a coincident event");

  a_collide_miss: assert property (
    (ev_vs_clr_miss != '0) |=>
    ((missed_event_flag & $past(ev_vs_clr_miss)) == $past(ev_vs_clr_miss)))
    else $error("lost event during clear not flagged");

  a_manual_beats_sub: assert property (
    s_manual_race |=> s_manual_race_kept)
    else $error("submission cleared a coincident manual set");

  a_manual_only_sub: assert property (
    1'b1 |=> ((manual_q & $past(man_keep)) == $past(man_keep)))
    else $error("manual bit dropped without submission");

  a_clear_spares_manual: assert property (
    (wr_req && sel_clear && !submit.valid) |=>
    ((manual_q & $past(manual_q)) == $past(manual_q)))
    else $error("clear write touched manual bits");

  a_chain_unmasked: assert property (
    (chained_event_vector != '0) |->
    ((pending_req & chained_event_vector) == chained_event_vector))
    else $error("chained event not presented");

  a_manual_unmasked: assert property (
    (manual_q != '0) |-> ((pending_req & manual_q) == manual_q))
    else $error("manual event not presented");

  a_masked_hidden: assert property (
    1'b1 |-> ((pending_req & ~enable_mask & ~manual_q &
               ~chained_event_vector) == '0))
    else $error("masked latch bit presented");

  // A miss can only come from a bit that was already pending
  a_miss_has_cause: assert property (
    1'b1 |=> ((missed_event_flag & ~$past(latch_q | manual_q)) == '0))
    else $error("missed flag without a pending bit");

  a_latch_read_back: assert property (
    (rd_req && sel_latch && !reg_req.shadow) |=>
    (reg_rsp.valid && reg_rsp.rdata == $past(latch_q)))
    else $error("latch read returned wrong value");

  a_latch_write_ignored: assert property (
    (wr_req && sel_latch && ext_event == '0 && !submit.valid) |=>
    (latch_q == $past(latch_q)))
    else $error("write changed read-only latch");

  a_unmapped_error: assert property (
    (reg_req.valid && !mapped) |=>
    (reg_rsp.valid && reg_rsp.error && reg_rsp.rdata == '0))
    else $error("unmapped access not refused");

endmodule : dcel_event_latch

`default_nettype wire

/* File: tb/dcel_prio_model.sv */
// Prioritiser model: submits the lowest pending channel after a delay.
// Assumes pending_req settles before the falling edge of clk.
`timescale 1ns/1ps
`default_nettype none
module dcel_prio_model (
  input  wire logic              clk,
  input  wire logic              go,
  input  wire logic [7:0]        delay,
  input  wire logic [31:0]       pending_req,
  output var  dcel_pkg::dcel_submit_t submit
);
  logic [7:0] cnt = 8'h00;
  initial submit = '0;
  function automatic logic [4:0] low(input logic [31:0] p);
    low = 5'h00;
    for (int i = 31; i >= 0; i--) if (p[i]) low = 5'(i);
  endfunction : low
  // Gap after each pulse so the cleared bit is seen before the next pick
  always @(negedge clk) begin
    submit.valid <= 1'b0;
    submit.channel <= ~submit.channel;
    if (go && pending_req != 32'h0 && !submit.valid) begin
      if (cnt < delay) cnt <= cnt + 8'h01;
      else begin
        cnt <= 8'h00;
        submit.valid <= 1'b1;
        submit.channel <= low(pending_req);
      end
    end
  end
endmodule : dcel_prio_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the channel event latch.
// Assumes the prioritiser model; region masks are driven here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, arst_n = 1'b0, go = 1'b0;
  logic [31:0] ext = '0, mask = '0, chain = '0, pend, mef, miss_s;
  logic [7:0][31:0] rae = '0;
  logic [7:0] dly = 8'h00;
  dcel_pkg::dcel_reg_req_t req = '0;
  dcel_pkg::dcel_reg_rsp_t rsp, rsp_s;
  dcel_pkg::dcel_submit_t sub;
  int failures = 0, compares = 0;
  always #12.5 clk = ~clk;
  dcel_event_latch #(.NUM_REGIONS(8)) uut (.clk(clk), .arst_n(arst_n),
    .ext_event(ext), .enable_mask(mask), .chained_event_vector(chain),
    .region_access_enable(rae), .reg_req(req), .reg_rsp(rsp),
    .submit(sub), .pending_req(pend), .missed_event_flag(mef));
  dcel_prio_model pm (.clk(clk), .go(go), .delay(dly),
    .pending_req(pend), .submit(sub));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  // Request and event share one edge so set-versus-clear can be staged
  task automatic acc(input logic w, s, input logic [2:0] r,
                     input logic [7:0] o, input logic [31:0] d, e);
    int n;
    req <= {1'b1, w, s, r, o, d};
    ext <= e;
    @(negedge clk);
    req <= '0;
    ext <= '0;
    miss_s = mef;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 2) begin
      @(negedge clk);
      n++;
    end
    chk(32'h1, {31'h0, rsp.valid});
    rsp_s = rsp;
    // Idle edge so a following request never re-drives req in this step
    @(negedge clk);
  endtask : acc
  task automatic rd(input logic [7:0] o);
    acc(1'b0, 1'b0, 3'h0, o, 32'h0, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    acc(1'b1, 1'b0, 3'h0, o, d, 32'h0);
  endtask : wr
  task automatic pulse(input logic [31:0] e);
    ext <= e;
    @(negedge clk);
    ext <= '0;
    miss_s = mef;
    @(negedge clk);
  endtask : pulse
  task automatic drain(input logic [31:0] m);
    int n;
    go <= 1'b1;
    for (n = 0; n < 30 && (pend & m) !== 32'h0; n++) @(negedge clk);
    go <= 1'b0;
    chk(32'h0, pend & m);
  endtask : drain
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_latch;
    rd(8'h00); chk(32'h0, rsp_s.rdata);
    wr(8'h08, 32'hFFFF_FFFF); rd(8'h08); chk(32'h0, rsp_s.rdata);
    pulse(32'h8000_0008); pulse(32'h8); chk(32'h0, miss_s);
    chk(32'h0, pend);
    repeat (3) @(negedge clk);
    rd(8'h00); chk(32'h8000_0008, rsp_s.rdata);
    wr(8'h08, 32'h0); rd(8'h00); chk(32'h8000_0008, rsp_s.rdata);
    wr(8'h08, 32'h8); rd(8'h00); chk(32'h8000_0000, rsp_s.rdata);
    wr(8'h08, 32'h8000_0000);
    $display("t_latch done");
  endtask : t_latch
  task automatic t_miss;
    mask <= 32'h20;
    pulse(32'h20); chk(32'h20, pend);
    pulse(32'h20); chk(32'h20, miss_s);
    dly <= 8'h03; drain(32'h20);
    rd(8'h00); chk(32'h0, rsp_s.rdata);
    mask <= 32'h80;
    pulse(32'h80); acc(1'b1, 1'b0, 3'h0, 8'h08, 32'h80, 32'h80);
    chk(32'h80, miss_s);
    rd(8'h00); chk(32'h80, rsp_s.rdata);
    wr(8'h08, 32'h80); acc(1'b1, 1'b0, 3'h0, 8'h08, 32'h80, 32'h80);
    chk(32'h0, miss_s);
    rd(8'h00); chk(32'h80, rsp_s.rdata);
    wr(8'h08, 32'h80); mask <= 32'h0;
    $display("t_miss done");
  endtask : t_miss
  task automatic t_manual;
    wr(8'h10, 32'h200); chk(32'h200, pend);
    rd(8'h10); chk(32'h200, rsp_s.rdata);
    wr(8'h10, 32'h200); chk(32'h200, miss_s);
    wr(8'h10, 32'h0); wr(8'h08, 32'h200);
    rd(8'h10); chk(32'h200, rsp_s.rdata);
    dly <= 8'h00; drain(32'h200);
    rd(8'h10); chk(32'h0, rsp_s.rdata);
    $display("t_manual done");
  endtask : t_manual
  task automatic t_bus;
    rd(8'h04);
    chk(32'h1, {31'h0, rsp_s.error});
    chk(32'h0, rsp_s.rdata);
    wr(8'h00, 32'hFFFF_FFFF); rd(8'h00); chk(32'h0, rsp_s.rdata);
    rae[1] <= 32'h404;
    acc(1'b1, 1'b1, 3'h1, 8'h10, 32'hFFFF_FFFF, 32'h0);
    acc(1'b1, 1'b1, 3'h2, 8'h10, 32'hFFFF_FFFF, 32'h0);
    rd(8'h10); chk(32'h404, rsp_s.rdata);
    rae[1] <= 32'h4;
    acc(1'b0, 1'b1, 3'h1, 8'h10, 32'h0, 32'h0);
    chk(32'h4, rsp_s.rdata);
    drain(32'h404);
    chain <= 32'h0010_0000; @(negedge clk);
    chk(32'h0010_0000, pend);
    chain <= 32'h0;
    $display("t_bus done");
  endtask : t_bus
  initial begin
    repeat (12) @(negedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    t_latch; t_miss; t_manual; t_bus;
    report_and_stop;
  end
  // Scenarios need well under 1000 cycles; allow a wide margin
  initial begin
    #50000;
    failures++;
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
